// [add_and_bitclear_execute.sv]
// Execute stage for add, AND and bit-clear instructions with an Avalon-MM register port.
//
// How it works
// - An add-literal word adds its low eight bits to the accumulator, stores the sum there and updates carry, digit carry and zero.
// - An AND-literal word ANDs its low eight bits into the accumulator and updates only the zero flag.
// - An add-register word adds the accumulator to the addressed file register and updates carry, digit carry and zero.
// - An AND-register word ANDs the accumulator with the addressed file register and updates only the zero flag.
// - For the register forms a destination bit of 0 sends the result to the accumulator.
// - For the register forms a destination bit of 1 writes the result back to the addressed file register.
// - A bit-clear word forces the selected bit of the addressed register low, keeps the other bits and leaves every flag alone.
// - The bit-clear reads the whole register, changes one bit and writes all eight bits back.
module add_and_bitclear_execute #(
  parameter int DATA_W   = exec_pkg::DATA_W,
  parameter int FADDR_W  = exec_pkg::FADDR_W,
  parameter int RETIRE_W = exec_pkg::RETIRE_W
) (
  // Clock and reset
  input  wire  logic                                   clk_sys_i,
  input  wire  logic                                   reset_n_i,
  // Instruction from the decoder
  input  wire  logic                                   instr_valid_i,
  input  wire  logic [exec_pkg::INSTR_W-1:0]           instr_i,
  output logic                                         instr_ready_o,
  // File register read port
  output logic       [FADDR_W-1:0]                     file_rd_addr_o,
  input  wire  logic [DATA_W-1:0]                      file_rdata_i,
  // File register write port and results
  output exec_pkg::file_wr_type                        file_wr_o,
  output logic       [DATA_W-1:0]                      acc_o,
  output exec_pkg::flags_type                          flags_o,
  // Avalon-MM slave
  input  wire  logic [exec_pkg::BUS_ADDR_W-1:0]        avs_address_i,
  input  wire  logic                                   avs_read_i,
  input  wire  logic                                   avs_write_i,
  input  wire  logic [exec_pkg::BUS_DATA_W-1:0]        avs_writedata_i,
  input  wire  logic [exec_pkg::BUS_BE_W-1:0]          avs_byteenable_i,
  output logic       [exec_pkg::BUS_DATA_W-1:0]        avs_readdata_o,
  output logic                                         avs_waitrequest_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic                              enable_q;
  logic                              enable_d;
  logic [DATA_W-1:0]                 acc_q;
  logic [DATA_W-1:0]                 acc_d;
  exec_pkg::flags_type               flags_q;
  exec_pkg::flags_type               flags_d;
  exec_pkg::file_wr_type             file_wr_q;
  exec_pkg::file_wr_type             file_wr_d;
  logic [RETIRE_W-1:0]               retired_q;
  logic [RETIRE_W-1:0]               retired_d;
  logic [exec_pkg::INSTR_W-1:0]      last_q;
  logic [exec_pkg::INSTR_W-1:0]      last_d;
  exec_pkg::bus_state_type           bus_state_q;
  exec_pkg::bus_state_type           bus_state_d;
  logic [exec_pkg::BUS_DATA_W-1:0]   readdata_q;
  logic [exec_pkg::BUS_DATA_W-1:0]   readdata_d;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  logic                              take;
  logic                              is_add_lit;
  logic                              is_and_lit;
  logic                              is_add_reg;
  logic                              is_and_reg;
  logic                              is_clr_bit;
  logic                              is_lit;
  logic                              is_reg;
  logic                              dest_file;
  logic [DATA_W-1:0]                 literal;
  logic [exec_pkg::BITPOS_W-1:0]     bitpos;

  assign take    = instr_valid_i && enable_q;
  // The spare bit of the add-literal form is outside its mask.
  assign is_add_lit = take &&
    ((instr_i & exec_pkg::MASK_ADD_LIT) == exec_pkg::MATCH_ADD_LIT);
  assign is_and_lit = take &&
    ((instr_i & exec_pkg::MASK_AND_LIT) == exec_pkg::MATCH_AND_LIT);
  assign is_add_reg = take &&
    ((instr_i & exec_pkg::MASK_ADD_REG) == exec_pkg::MATCH_ADD_REG);
  assign is_and_reg = take &&
    ((instr_i & exec_pkg::MASK_AND_REG) == exec_pkg::MATCH_AND_REG);
  assign is_clr_bit = take &&
    ((instr_i & exec_pkg::MASK_CLR_BIT) == exec_pkg::MATCH_CLR_BIT);
  assign is_lit     = is_add_lit || is_and_lit;
  assign is_reg     = is_add_reg || is_and_reg;
  assign dest_file  = instr_i[exec_pkg::DEST_POS];
  assign literal    = instr_i[exec_pkg::LIT_LSB +: DATA_W];
  assign bitpos     = instr_i[exec_pkg::BITPOS_LSB +: exec_pkg::BITPOS_W];

  // ------------------------------------------------------------------
  // Operand fetch with write forwarding
  // ------------------------------------------------------------------
  // The write port is registered, so the register file holds the old value
  // for one more cycle; the pending write is forwarded to avoid a stale read.
  logic                              fwd_hit;
  logic [DATA_W-1:0]                 file_val;
  exec_pkg::alu_op_type              alu_op;
  logic [DATA_W-1:0]                 alu_b;
  logic [DATA_W-1:0]                 alu_res;
  logic                              alu_c;
  logic                              alu_dc;
  logic                              alu_z;

  assign file_rd_addr_o = instr_i[exec_pkg::FADDR_LSB +: FADDR_W];
  assign fwd_hit  = file_wr_q.en && (file_wr_q.addr == file_rd_addr_o);
  assign file_val = fwd_hit ? file_wr_q.data : file_rdata_i;
  assign alu_b    = is_lit ? literal : file_val;
  assign alu_op   = (is_add_lit || is_add_reg) ? exec_pkg::ALU_ADD :
                    (is_and_lit || is_and_reg) ? exec_pkg::ALU_AND :
                    exec_pkg::ALU_CLR;

  exec_alu #(
    .DATA_W   (DATA_W),
    .NIBBLE_W (exec_pkg::NIBBLE_W),
    .BITPOS_W (exec_pkg::BITPOS_W)
  ) u_alu (
    .op_i          (alu_op),
    .bitpos_i      (bitpos),
    .a_i           (acc_q),
    .b_i           (alu_b),
    .result_o      (alu_res),
    .carry_o       (alu_c),
    .digit_carry_o (alu_dc),
    .zero_o        (alu_z)
  );

  // ------------------------------------------------------------------
  // Result routing
  // ------------------------------------------------------------------
  logic                              to_acc;
  logic                              to_file;
  logic                              upd_cdc;
  logic                              upd_z;

  assign to_acc  = is_lit || (is_reg && !dest_file);
  assign to_file = (is_reg && dest_file) || is_clr_bit;
  assign upd_cdc = is_add_lit || is_add_reg;
  assign upd_z   = upd_cdc || is_and_lit || is_and_reg;

  // ------------------------------------------------------------------
  // Avalon-MM decode
  // ------------------------------------------------------------------
  // Every access is answered one cycle after it is seen; an unmapped read
  // returns zero and an unmapped write is dropped.
  logic                              bus_req;
  logic                              bus_wr;
  logic                              hit_ctrl;
  logic                              hit_acc;
  logic                              hit_flags;
  logic                              hit_retired;
  logic                              hit_last;
  logic [exec_pkg::BUS_DATA_W-1:0]   rd_mux;

  assign bus_req     = avs_read_i || avs_write_i;
  assign bus_wr      = (bus_state_q == exec_pkg::BUS_ACK) && avs_write_i &&
                       avs_byteenable_i[0];
  assign hit_ctrl    = (avs_address_i == exec_pkg::OFS_CTRL);
  assign hit_acc     = (avs_address_i == exec_pkg::OFS_ACC);
  assign hit_flags   = (avs_address_i == exec_pkg::OFS_FLAGS);
  assign hit_retired = (avs_address_i == exec_pkg::OFS_RETIRED);
  assign hit_last    = (avs_address_i == exec_pkg::OFS_LAST);
  assign rd_mux =
    hit_ctrl    ? exec_pkg::BUS_DATA_W'(enable_q) :
    hit_acc     ? exec_pkg::BUS_DATA_W'(acc_q) :
    hit_flags   ? exec_pkg::BUS_DATA_W'(flags_q) :
    hit_retired ? exec_pkg::BUS_DATA_W'(retired_q) :
    hit_last    ? exec_pkg::BUS_DATA_W'(last_q) : '0;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // An instruction result wins over a software write to the same register
  // in the same cycle, so no computed result is ever lost.
  always_comb begin
    enable_d    = enable_q;
    acc_d       = acc_q;
    flags_d     = flags_q;
    file_wr_d   = '0;
    retired_d   = retired_q;
    last_d      = last_q;
    bus_state_d = bus_state_q;
    readdata_d  = readdata_q;
    if (bus_wr && hit_ctrl) begin
      enable_d = avs_writedata_i[exec_pkg::CTRL_EN_POS];
    end
    if (bus_wr && hit_acc) begin
      acc_d = avs_writedata_i[DATA_W-1:0];
    end
    if (bus_wr && hit_flags) begin
      flags_d = exec_pkg::flags_type'(avs_writedata_i[exec_pkg::FLAGS_W-1:0]);
    end
    if (to_acc) begin
      acc_d = alu_res;
    end
    if (upd_cdc) begin
      flags_d.c                = alu_c;
      flags_d.digit_carry_flag = alu_dc;
    end
    if (upd_z) begin
      flags_d.z = alu_z;
    end
    if (to_file) begin
      file_wr_d.en   = 1'b1;
      file_wr_d.addr = file_rd_addr_o;
      file_wr_d.data = alu_res;
    end
    if (is_lit || is_reg || is_clr_bit) begin
      retired_d = retired_q + RETIRE_W'(1);
      last_d    = instr_i;
    end
    case (bus_state_q)
      exec_pkg::BUS_IDLE: begin
        if (bus_req) begin
          bus_state_d = exec_pkg::BUS_ACK;
          readdata_d  = rd_mux;
        end
      end
      exec_pkg::BUS_ACK: begin
        bus_state_d = exec_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_d = exec_pkg::BUS_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_q    <= exec_pkg::CTRL_EN_RST;
      acc_q       <= exec_pkg::ACC_RST;
      flags_q     <= '0;
      file_wr_q   <= '0;
      retired_q   <= '0;
      last_q      <= '0;
      bus_state_q <= exec_pkg::BUS_IDLE;
      readdata_q  <= '0;
    end else begin
      enable_q    <= enable_d;
      acc_q       <= acc_d;
      flags_q     <= flags_d;
      file_wr_q   <= file_wr_d;
      retired_q   <= retired_d;
      last_q      <= last_d;
      bus_state_q <= bus_state_d;
      readdata_q  <= readdata_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign instr_ready_o     = enable_q;
  assign file_wr_o         = file_wr_q;
  assign acc_o             = acc_q;
  assign flags_o           = flags_q;
  assign avs_readdata_o    = readdata_q;
  assign avs_waitrequest_o = (bus_state_q != exec_pkg::BUS_ACK);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  chk_add_lit_sum: assert property (
    is_add_lit |=> {flags_q.c, acc_q} ==
      ($past({1'b0, acc_q}) + $past({1'b0, literal})))
    else $error("add-literal sum or carry wrong");

  chk_and_lit_flags: assert property (
    is_and_lit && !(bus_wr && hit_flags) |=>
      acc_q == ($past(acc_q) & $past(literal)) &&
      flags_q.c == $past(flags_q.c) &&
      flags_q.digit_carry_flag == $past(flags_q.digit_carry_flag) &&
      flags_q.z == (acc_q == '0))
    else $error("AND-literal result or flags wrong");

  chk_add_reg_flags: assert property (
    is_add_reg |=> flags_q.digit_carry_flag ==
      ($past(acc_q[exec_pkg::NIBBLE_W-1:0]) +
       $past({1'b0, file_val[exec_pkg::NIBBLE_W-1:0]}) > 5'h0F))
    else $error("add-register digit carry wrong");

  chk_and_reg_file: assert property (
    is_and_reg && dest_file |=> file_wr_q.en &&
      file_wr_q.data == ($past(acc_q) & $past(file_val)) &&
      flags_q.z == (file_wr_q.data == '0))
    else $error("AND-register result or zero flag wrong");

  chk_dest_acc: assert property (
    is_reg && !dest_file |=> !file_wr_q.en && acc_q == ($past(is_add_reg) ?
      $past(acc_q) + $past(file_val) : $past(acc_q) & $past(file_val)))
    else $error("register form with accumulator destination misrouted");

  chk_dest_file: assert property (
    is_reg && dest_file && !(bus_wr && hit_acc) |=>
      file_wr_q.en && file_wr_q.addr == $past(file_rd_addr_o) &&
      acc_q == $past(acc_q))
    else $error("register form with file destination misrouted");

  chk_clear_bit: assert property (
    is_clr_bit && !(bus_wr && hit_flags) |=> file_wr_q.en &&
      file_wr_q.data[$past(bitpos)] == 1'b0 && flags_q == $past(flags_q))
    else $error("bit clear left the bit set or changed a flag");

  chk_clear_rmw: assert property (
    is_clr_bit |=> (file_wr_q.data | ({{(DATA_W-1){1'b0}}, 1'b1} <<
      $past(bitpos))) == ($past(file_val) | ({{(DATA_W-1){1'b0}}, 1'b1} <<
      $past(bitpos))))
    else $error("bit clear disturbed another bit");

  chk_one_cycle: assert property (
    take && (is_lit || is_reg || is_clr_bit) |=>
      retired_q == $past(retired_q) + RETIRE_W'(1) && last_q == $past(instr_i))
    else $error("instruction did not complete in one cycle");

  chk_bus_answer: assert property (
    bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not exactly one cycle after request");

endmodule

// [exec_pkg.sv]
// Shared constants, field layouts and types for the add and bit-clear execute block.
package exec_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int INSTR_W    = 14;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int BITPOS_W   = 3;
  localparam int NIBBLE_W   = 4;
  localparam int BUS_ADDR_W = 8;
  localparam int BUS_DATA_W = 32;
  localparam int BUS_BE_W   = 4;
  localparam int RETIRE_W   = 16;

  // ------------------------------------------------------------------
  // Opcode masks and match values
  // ------------------------------------------------------------------
  localparam logic [INSTR_W-1:0] MASK_ADD_LIT  = 14'h3E00;
  localparam logic [INSTR_W-1:0] MATCH_ADD_LIT = 14'h3E00;
  localparam logic [INSTR_W-1:0] MASK_AND_LIT  = 14'h3F00;
  localparam logic [INSTR_W-1:0] MATCH_AND_LIT = 14'h3900;
  localparam logic [INSTR_W-1:0] MASK_ADD_REG  = 14'h3F00;
  localparam logic [INSTR_W-1:0] MATCH_ADD_REG = 14'h0700;
  localparam logic [INSTR_W-1:0] MASK_AND_REG  = 14'h3F00;
  localparam logic [INSTR_W-1:0] MATCH_AND_REG = 14'h0500;
  localparam logic [INSTR_W-1:0] MASK_CLR_BIT  = 14'h3C00;
  localparam logic [INSTR_W-1:0] MATCH_CLR_BIT = 14'h1000;

  // ------------------------------------------------------------------
  // Instruction field positions
  // ------------------------------------------------------------------
  localparam int LIT_LSB    = 0;
  localparam int FADDR_LSB  = 0;
  localparam int DEST_POS   = 7;
  localparam int BITPOS_LSB = 7;

  // ------------------------------------------------------------------
  // Register map, byte addresses of aligned words
  // ------------------------------------------------------------------
  localparam logic [BUS_ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [BUS_ADDR_W-1:0] OFS_ACC     = 8'h04;
  localparam logic [BUS_ADDR_W-1:0] OFS_FLAGS   = 8'h08;
  localparam logic [BUS_ADDR_W-1:0] OFS_RETIRED = 8'h0C;
  localparam logic [BUS_ADDR_W-1:0] OFS_LAST    = 8'h10;
  localparam int                    CTRL_EN_POS = 0;
  localparam logic                  CTRL_EN_RST = 1'b1;
  localparam logic [DATA_W-1:0]     ACC_RST     = 8'h00;
  localparam int                    FLAGS_W     = 3;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ALU_ADD = 2'h0,
    ALU_AND = 2'h1,
    ALU_CLR = 2'h3
  } alu_op_type;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'h0,
    BUS_ACK  = 1'h1
  } bus_state_type;

  typedef struct packed {
    logic z;
    logic digit_carry_flag;
    logic c;
  } flags_type;

  typedef struct packed {
    logic               en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } file_wr_type;

endpackage

// [exec_alu.sv]
// Eight-bit adder, AND and bit-clear unit with carry, digit carry and zero results.
module exec_alu #(
  parameter int DATA_W   = exec_pkg::DATA_W,
  parameter int NIBBLE_W = exec_pkg::NIBBLE_W,
  parameter int BITPOS_W = exec_pkg::BITPOS_W
) (
  // Operation
  input  wire exec_pkg::alu_op_type op_i,
  input  wire logic [BITPOS_W-1:0]  bitpos_i,
  // Operands
  input  wire logic [DATA_W-1:0]    a_i,
  input  wire logic [DATA_W-1:0]    b_i,
  // Results
  output logic      [DATA_W-1:0]    result_o,
  output logic                      carry_o,
  output logic                      digit_carry_o,
  output logic                      zero_o
);

  logic [DATA_W:0]     sum_full;
  logic [NIBBLE_W:0]   sum_nibble;
  logic [DATA_W-1:0]   clr_mask;
  logic [DATA_W-1:0]   and_val;
  logic [DATA_W-1:0]   clr_val;

  assign sum_full   = {1'b0, a_i} + {1'b0, b_i};
  assign sum_nibble = {1'b0, a_i[NIBBLE_W-1:0]} + {1'b0, b_i[NIBBLE_W-1:0]};
  assign clr_mask   = ~({{(DATA_W-1){1'b0}}, 1'b1} << bitpos_i);
  assign and_val    = a_i & b_i;
  // The whole register passes through; only the selected bit is forced low.
  assign clr_val    = b_i & clr_mask;

  assign result_o      = (op_i == exec_pkg::ALU_ADD) ? sum_full[DATA_W-1:0] :
                         (op_i == exec_pkg::ALU_AND) ? and_val : clr_val;
  assign carry_o       = sum_full[DATA_W];
  assign digit_carry_o = sum_nibble[NIBBLE_W];
  assign zero_o        = (result_o == '0);

endmodule

// [tb_add_and_bitclear_execute.sv]
// Random self-checking bench for the add, AND and bit-clear execute block.
module tb_add_and_bitclear_execute;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys_i        = 1'b0;
  logic                  reset_n_i        = 1'b0;
  logic                  instr_valid_i    = 1'b0;
  logic [13:0]           instr_i          = 14'h0000;
  logic                  instr_ready_o;
  logic [6:0]            file_rd_addr_o;
  logic [7:0]            file_rdata_i;
  exec_pkg::file_wr_type file_wr_o;
  logic [7:0]            acc_o;
  exec_pkg::flags_type   flags_o;
  logic [7:0]            avs_address_i    = 8'h00;
  logic                  avs_read_i       = 1'b0;
  logic                  avs_write_i      = 1'b0;
  logic [31:0]           avs_writedata_i  = 32'h0000_0000;
  logic [3:0]            avs_byteenable_i = 4'hf;
  logic [31:0]           avs_readdata_o;
  logic                  avs_waitrequest_o;
  logic [7:0]            rf [0:127];
  logic [7:0]            fm [0:127];
  logic [7:0]            acc_m;
  logic [2:0]            flg_m;
  logic                  en_m;
  logic                  e_en;
  logic                  pend;
  logic [14:0]           e_wr;
  logic [15:0]           ret_m;
  logic [13:0]           last_m;
  int                    num_errors = 0;
  int                    n_compared = 0;

  add_and_bitclear_execute dut_u (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .file_rd_addr_o(file_rd_addr_o),
    .file_rdata_i(file_rdata_i), .file_wr_o(file_wr_o), .acc_o(acc_o), .flags_o(flags_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

  always #2 clk_sys_i = ~clk_sys_i;

  // The register file lags one edge behind the write pulse, so the design must forward.
  assign file_rdata_i = rf[file_rd_addr_o];
  always @(posedge clk_sys_i) if (file_wr_o.en === 1'b1) rf[file_wr_o.addr] <= file_wr_o.data;

  // ------------------------------------------------------------------
  // Checking and reference model
  // ------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [10:0] addf(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = a + b;
    return {s[7:0] == 8'h00, (a[3:0] + b[3:0]) > 5'h0f, s[8], s[7:0]};
  endfunction

  function automatic logic [13:0] rnd_word(input int k);
    logic [7:0] lit;
    logic [6:0] fa;
    lit = 8'($urandom);
    fa = {4'h0, 3'($urandom)};
    case (k)
      0: return {5'b11111, 1'($urandom), lit};
      1: return {6'b111001, lit};
      2: return {6'b000111, 1'($urandom), fa};
      3: return {6'b000101, 1'($urandom), fa};
      4: return {4'b0100, 3'($urandom), fa};
      default: return {6'b111010, lit};
    endcase
  endfunction

  task automatic plan(input logic [13:0] w, input logic v);
    logic [7:0] f, r;
    logic d, hit;
    f = fm[w[6:0]];
    d = w[7];
    hit = v & en_m;
    e_en = 1'b0;
    r = 8'h00;
    if (hit) begin
      casez (w[13:8])
        6'b11111?: {flg_m, acc_m} = addf(acc_m, w[7:0]);
        6'b111001: begin acc_m = acc_m & w[7:0]; flg_m[2] = (acc_m == 8'h00); end
        6'b000111: {flg_m, r} = addf(acc_m, f);
        6'b000101: begin r = acc_m & f; flg_m[2] = (r == 8'h00); end
        6'b0100??: begin r = f & ~(8'h01 << w[9:7]); d = 1'b1; end
        default: hit = 1'b0;
      endcase
    end
    if (hit && !w[13] && d) begin fm[w[6:0]] = r; e_en = 1'b1; e_wr = {w[6:0], r}; end
    else if (hit && !w[13]) acc_m = r;
    if (hit) begin ret_m++; last_m = w; end
  endtask

  task automatic issue(input logic [13:0] w, input logic v);
    @(posedge clk_sys_i);
    instr_i <= w;
    instr_valid_i <= v;
    #1;
    if (pend) begin
      check("ready", instr_ready_o, en_m);
      check("acc", acc_o, acc_m);
      check("flags", flags_o, flg_m);
      check("wr_en", file_wr_o.en, e_en);
      if (e_en) check("wr", {file_wr_o.addr, file_wr_o.data}, e_wr);
    end
    plan(w, v);
    pend = 1'b1;
  endtask

  // Avalon master: holds the request until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (wr && be[0] && a == exec_pkg::OFS_ACC) acc_m = wd[7:0];
    if (wr && be[0] && a == exec_pkg::OFS_FLAGS) flg_m = wd[2:0];
    if (wr && be[0] && a == exec_pkg::OFS_CTRL) en_m = wd[0];
  endtask

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [13:0] corner [0:8];
    corner = '{14'h3E15, 14'h3EF0, 14'h3900, 14'h3F01, 14'h0785, 14'h1385, 14'h1005,
               14'h0505, 14'h0585};
    void'($urandom(32'h712b));
    for (int i = 0; i < 128; i++) begin rf[i] = 8'($urandom); fm[i] = rf[i]; end
    acc_m = 8'h00; flg_m = 3'h0; en_m = 1'b1; ret_m = 16'h0000; last_m = 14'h0000;
    pend = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1;
    check("rst_acc", {acc_o, flags_o, instr_ready_o, file_wr_o.en, avs_waitrequest_o}, 32'h0000_0005);
    bus(1'b0, exec_pkg::OFS_CTRL, 32'h0000_0000, 4'hf, rd);
    check("ctrl", rd, 32'h0000_0001);
    bus(1'b0, 8'h20, 32'h0000_0000, 4'hf, rd);
    check("unmapped", rd, 32'h0000_0000);
    $display("test reset done");
    // Corner words, back to back, with repeated addresses to hit forwarding.
    bus(1'b1, exec_pkg::OFS_ACC, 32'h0000_0010, 4'hf, rd);
    foreach (corner[i]) issue(corner[i], 1'b1);
    issue(14'h0000, 1'b0);
    $display("test corner done");
    for (int i = 0; i < 400; i++) issue(rnd_word($urandom_range(0, 5)), $urandom_range(0, 9) != 0);
    issue(14'h0000, 1'b0);
    $display("test random done");
    // Disabled execute must ignore every word.
    bus(1'b1, exec_pkg::OFS_CTRL, 32'h0000_0000, 4'hf, rd);
    for (int i = 0; i < 20; i++) issue(rnd_word($urandom_range(0, 4)), 1'b1);
    issue(14'h0000, 1'b0);
    bus(1'b1, exec_pkg::OFS_CTRL, 32'h0000_0001, 4'hf, rd);
    bus(1'b1, exec_pkg::OFS_ACC, 32'h0000_00AA, 4'h0, rd);
    bus(1'b0, exec_pkg::OFS_ACC, 32'h0000_0000, 4'hf, rd);
    check("acc_reg", rd, {24'h0, acc_m});
    $display("test disable done");
    bus(1'b1, exec_pkg::OFS_FLAGS, 32'h0000_0005, 4'hf, rd);
    bus(1'b0, exec_pkg::OFS_FLAGS, 32'h0000_0000, 4'hf, rd);
    check("flags_reg", rd, {29'h0, flg_m});
    bus(1'b0, exec_pkg::OFS_RETIRED, 32'h0000_0000, 4'hf, rd);
    check("retired", rd, {16'h0, ret_m});
    bus(1'b0, exec_pkg::OFS_LAST, 32'h0000_0000, 4'hf, rd);
    check("last", rd, {18'h0, last_m});
    issue(14'h0000, 1'b0);
    $display("test registers done");
    tally_and_finish();
  end

  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
